// file: rtl/lvi_top.sv
// low-voltage interrupt unit: enable sequencing, fall/rise detection, flags, interrupt request
// assumes comparator levels arrive asynchronously; registers reached over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module lvi_top
	import lvi_pkg::*;
#(
	parameter int SETTLE_WAIT = SETTLE_CYCLES
) (
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// register bus
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic      [31:0]   hrdata,
	// comparator levels: [0] below fall level, [1] above rise level, [2] below reset level
	input  wire logic [CMP_W-1:0] supply_cmp,
	// outputs to the system
	output logic               detect_signal_n,
	output logic               external_interrupt_zero
);
	// ==========================================================
	// elaboration checks
	initial begin
		if (SETTLE_WAIT < 1 || SETTLE_WAIT >= (1 << SETTLE_CNT_W))
			$error("lvi_top: SETTLE_WAIT out of range");
	end

	localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST = SETTLE_CNT_W'(SETTLE_WAIT);

	// ==========================================================
	// declarations
	lvi_req_t               req;
	logic [31:0]            rdata;
	logic [CMP_W-1:0]       cmp_s;
	lvi_ctrl_t              ctrl_reg;
	lvi_ctrl_t              ctrl_next;
	lvi_state_t             state_reg;
	lvi_state_t             state_next;
	logic [SETTLE_CNT_W-1:0] settle_cnt_reg;
	logic                   fall_flag_reg;
	logic                   rise_flag_reg;
	logic                   seq_err_reg;
	logic                   reset_seen_reg;
	logic                   armed;
	logic                   fall_ev;
	logic                   rise_ev;
	logic                   ctrl_wr;
	logic                   stat_wr;
	logic                   bad_shutdown;

	// ==========================================================
	// bus front end and synchroniser
	lvi_ahb_slave u_bus (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req),
		.rdata     (rdata)
	);

	lvi_sync #(
		.WIDTH (CMP_W)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (supply_cmp),
		.sync_out (cmp_s)
	);

	// ==========================================================
	// control register
	assign ctrl_wr = req.wr && (req.addr == OFS_CTRL);
	assign stat_wr = req.wr && (req.addr == OFS_STATUS);

	always_comb begin
		ctrl_next.detect_circuit_enable = req.wdata[CTRL_DET_EN_BIT];
		ctrl_next.fall_interrupt_enable = req.wdata[CTRL_FALL_IE_BIT];
		ctrl_next.rise_interrupt_enable = req.wdata[CTRL_RISE_IE_BIT];
	end

	// dropping the detect enable and at least one interrupt enable in one write, leaving none set, is flagged; the write still takes effect
	assign bad_shutdown = ctrl_wr && ctrl_reg.detect_circuit_enable
		&& (ctrl_reg.fall_interrupt_enable || ctrl_reg.rise_interrupt_enable)
		&& !ctrl_next.detect_circuit_enable
		&& !ctrl_next.fall_interrupt_enable && !ctrl_next.rise_interrupt_enable;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_reg.detect_circuit_enable <= CTRL_RESET[CTRL_DET_EN_BIT];
			ctrl_reg.fall_interrupt_enable <= CTRL_RESET[CTRL_FALL_IE_BIT];
			ctrl_reg.rise_interrupt_enable <= CTRL_RESET[CTRL_RISE_IE_BIT];
		end else if (ctrl_wr) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ==========================================================
	// sequencing: standby, reference settling, watching
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_STANDBY: begin
				if (ctrl_reg.detect_circuit_enable) begin
					state_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (!ctrl_reg.detect_circuit_enable) begin
					state_next = ST_STANDBY;
				end else if (settle_cnt_reg == SETTLE_LAST) begin
					state_next = ST_WATCH;
				end
			end
			ST_WATCH: begin
				if (!ctrl_reg.detect_circuit_enable) begin
					state_next = ST_STANDBY;
				end
			end
			default: begin
				state_next = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= ST_STANDBY;
		end else begin
			state_reg <= state_next;
		end
	end

	// the wait is enforced in hardware too, so early interrupt enables are harmless
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			settle_cnt_reg <= '0;
		end else if (state_reg == ST_SETTLE && settle_cnt_reg != SETTLE_LAST) begin
			settle_cnt_reg <= settle_cnt_reg + 1'b1;
		end else if (state_reg == ST_STANDBY) begin
			settle_cnt_reg <= '0;
		end
	end

	// ==========================================================
	// detection
	assign armed   = (state_reg == ST_WATCH);
	assign fall_ev = armed && detect_signal_n && cmp_s[CMP_FALL_BIT];
	assign rise_ev = armed && !detect_signal_n && cmp_s[CMP_RISE_BIT]
		&& !reset_seen_reg;

	// a dip below the reset level blocks recovery until the detector is re-armed
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reset_seen_reg <= 1'b0;
		end else if (!armed) begin
			reset_seen_reg <= 1'b0;
		end else if (!detect_signal_n && cmp_s[CMP_RESET_BIT]) begin
			reset_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			detect_signal_n <= 1'b1;
		end else if (!armed) begin
			detect_signal_n <= 1'b1;
		end else if (fall_ev) begin
			detect_signal_n <= 1'b0;
		end else if (rise_ev) begin
			detect_signal_n <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			external_interrupt_zero <= 1'b0;
		end else begin
			external_interrupt_zero <= (fall_ev && ctrl_reg.fall_interrupt_enable)
				|| (rise_ev && ctrl_reg.rise_interrupt_enable);
		end
	end

	// ==========================================================
	// status flags: writing 0 clears, a same-cycle event wins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			fall_flag_reg <= 1'b0;
		end else if (fall_ev) begin
			fall_flag_reg <= 1'b1;
		end else if (stat_wr && !req.wdata[STAT_FALL_BIT]) begin
			fall_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rise_flag_reg <= 1'b0;
		end else if (rise_ev && ctrl_reg.rise_interrupt_enable) begin
			rise_flag_reg <= 1'b1;
		end else if (stat_wr && !req.wdata[STAT_RISE_BIT]) begin
			rise_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			seq_err_reg <= 1'b0;
		end else if (bad_shutdown) begin
			seq_err_reg <= 1'b1;
		end else if (stat_wr && !req.wdata[STAT_SEQERR_BIT]) begin
			seq_err_reg <= 1'b0;
		end
	end

	// ==========================================================
	// read-back; unmapped offsets read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (req.addr == OFS_CTRL) begin
			rdata[CTRL_DET_EN_BIT]  = ctrl_reg.detect_circuit_enable;
			rdata[CTRL_FALL_IE_BIT] = ctrl_reg.fall_interrupt_enable;
			rdata[CTRL_RISE_IE_BIT] = ctrl_reg.rise_interrupt_enable;
		end else if (req.addr == OFS_STATUS) begin
			rdata[STAT_FALL_BIT]    = fall_flag_reg;
			rdata[STAT_RISE_BIT]    = rise_flag_reg;
			rdata[STAT_SEQERR_BIT]  = seq_err_reg;
			rdata[STAT_SETTLED_BIT] = armed;
			rdata[STAT_LEVEL_BIT]   = detect_signal_n;
		end
	end

	// ==========================================================
	// checks
	a_standby_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		(state_reg == ST_STANDBY) |=> detect_signal_n && !external_interrupt_zero)
		else $error("unit active while in standby");

	a_settle_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		armed |-> settle_cnt_reg == SETTLE_LAST)
		else $error("watching before the settling wait ended");

	a_fall_detect: assert property (@(posedge core_clk) disable iff (!rst_n)
		fall_ev |=> !detect_signal_n && fall_flag_reg)
		else $error("fall not reported");

	a_fall_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
		fall_ev && ctrl_reg.fall_interrupt_enable |=> external_interrupt_zero && fall_flag_reg)
		else $error("fall interrupt not raised with flag");

	a_irq_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(external_interrupt_zero) |-> $past(fall_ev) || $past(rise_ev))
		else $error("interrupt without a detection");

	a_rise_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
		rise_ev |=> detect_signal_n ##1 detect_signal_n || !armed || $past(fall_ev))
		else $error("detect signal not restored on rise");

	a_reset_block: assert property (@(posedge core_clk) disable iff (!rst_n)
		reset_seen_reg && armed |=> $stable(detect_signal_n) || !armed)
		else $error("recovered after dropping below reset level");

	a_rise_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		rise_ev && ctrl_reg.rise_interrupt_enable |=> rise_flag_reg && external_interrupt_zero)
		else $error("rise flag or interrupt missing");

	a_fall_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(detect_signal_n) |-> $past(fall_ev))
		else $error("detect signal dropped without a fall");

	a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		fall_flag_reg && !(stat_wr && !req.wdata[STAT_FALL_BIT]) |=> fall_flag_reg)
		else $error("fall flag lost without a clear");

	a_fall_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		fall_ev && !ctrl_reg.fall_interrupt_enable |=> !external_interrupt_zero)
		else $error("fall raised a request while its enable was clear");

	a_rise_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(detect_signal_n) |-> $past(rise_ev) || !$past(armed))
		else $error("detect signal restored without a rise");

	a_rise_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rise_flag_reg) |-> $past(rise_ev) && $past(ctrl_reg.rise_interrupt_enable))
		else $error("rise flag set without its enable");

	a_seq_err_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		bad_shutdown |=> seq_err_reg)
		else $error("single-write shutdown not flagged");
endmodule
`default_nettype wire

// file: rtl/lvi_pkg.sv
// constants, register map and carrier types of the low-voltage interrupt unit
// assumes one 40 MHz core clock and an AHB-Lite register port
// Operation
// - after power-on reset stay in module-standby
// - supply falls: detect signal low, fall flag set
// - fall with fall enable raises interrupt simultaneously
// - supply rises without reset drop: detect signal high
package lvi_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS   = 25;
	localparam int SETTLE_TIME_NS  = 50_000;
	localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CNT_W    = 12;

	// ==========================================================
	// register map
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STATUS = 8'h04;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// control bit positions
	localparam int CTRL_RISE_IE_BIT = 0;
	localparam int CTRL_FALL_IE_BIT = 1;
	localparam int CTRL_DET_EN_BIT  = 7;

	// status bit positions
	localparam int STAT_FALL_BIT    = 0;
	localparam int STAT_RISE_BIT    = 1;
	localparam int STAT_SEQERR_BIT  = 2;
	localparam int STAT_SETTLED_BIT = 4;
	localparam int STAT_LEVEL_BIT   = 5;

	// comparator input positions
	localparam int CMP_FALL_BIT  = 0;
	localparam int CMP_RISE_BIT  = 1;
	localparam int CMP_RESET_BIT = 2;
	localparam int CMP_W         = 3;

	// ==========================================================
	// types
	typedef struct packed {
		logic detect_circuit_enable;
		logic fall_interrupt_enable;
		logic rise_interrupt_enable;
	} lvi_ctrl_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} lvi_req_t;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_SETTLE  = 2'b01,
		ST_WATCH   = 2'b10
	} lvi_state_t;

endpackage

// file: rtl/lvi_sync.sv
// two-flop synchroniser for the comparator levels
// assumes inputs are slow levels from the analog side
`timescale 1ns/1ps
`default_nettype none
module lvi_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) $error("lvi_sync: WIDTH must be at least 1");
	end

	// first stage is read only by the second
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// file: rtl/lvi_ahb_slave.sv
// AHB-Lite slave front end: one wait state per transfer, always OKAY
// assumes single word transfers; register file answers reads combinationally
`timescale 1ns/1ps
`default_nettype none
module lvi_ahb_slave
	import lvi_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// register side
	output lvi_req_t         req,
	input  wire logic [31:0] rdata
);
	logic              pend_reg;
	logic              pend_wr_reg;
	logic [ADDR_W-1:0] pend_addr_reg;
	logic              accept;

	// hsize is not checked: only whole words are issued
	assign accept = hsel && htrans[1] && hready;

	// the wait state lets a write land before any following read is sampled
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pend_reg      <= 1'b0;
			pend_wr_reg   <= 1'b0;
			pend_addr_reg <= '0;
			hreadyout     <= 1'b1;
		end else if (accept) begin
			pend_reg      <= 1'b1;
			pend_wr_reg   <= hwrite;
			pend_addr_reg <= haddr[ADDR_W-1:0];
			hreadyout     <= 1'b0;
		end else begin
			pend_reg  <= 1'b0;
			hreadyout <= 1'b1;
		end
	end

	always_comb begin
		req.wr    = pend_reg && pend_wr_reg;
		req.rd    = pend_reg && !pend_wr_reg;
		req.addr  = pend_addr_reg;
		req.wdata = hwdata;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
			hresp  <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (req.rd) begin
				hrdata <= rdata;
			end
		end
	end

	a_bus_wait_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		accept |=> !hreadyout ##1 hreadyout) else $error("transfer did not take one wait state");
endmodule
`default_nettype wire

// file: bench/lvi_supply_model.sv
// far-side model: supply comparators and the interrupt controller
// assumes the bench sets a supply zone; request pulses are counted on the core clock
`timescale 1ns/1ps
`default_nettype none
module lvi_supply_model
	import lvi_pkg::*;
(
	// clock
	input  wire logic             core_clk,
	// supply zone: 0 above rise level, 1 mid band, 2 below fall level, 3 below reset level
	input  wire logic [1:0]       zone,
	// comparator levels
	output logic      [CMP_W-1:0] supply_cmp,
	// interrupt controller side
	input  wire logic             external_interrupt_zero,
	output int                    irq_count
);
	// ==========================================================
	// comparators: a lower zone also trips the higher thresholds
	always_comb begin
		supply_cmp                = '0;
		supply_cmp[CMP_FALL_BIT]  = (zone >= 2'h2);
		supply_cmp[CMP_RISE_BIT]  = (zone == 2'h0);
		supply_cmp[CMP_RESET_BIT] = (zone == 2'h3);
	end

	// ==========================================================
	// interrupt controller: one count per request cycle
	initial irq_count = 0;
	always @(posedge core_clk) begin
		if (external_interrupt_zero === 1'b1) begin
			irq_count <= irq_count + 1;
		end
	end
endmodule
`default_nettype wire

// file: bench/lvi_top_bench.sv
// self-checking bench of the low-voltage interrupt unit
// assumes a single AHB-Lite master and the comparator model beside the design
`timescale 1ns/1ps
`default_nettype none
module lvi_top_bench;
	import lvi_pkg::*;
	// short settle count keeps the run brief
	localparam int          SW     = 4;
	localparam logic [31:0] C_DET  = 32'h0000_0001 << CTRL_DET_EN_BIT;
	localparam logic [31:0] C_FALL = 32'h0000_0001 << CTRL_FALL_IE_BIT;
	localparam logic [31:0] C_RISE = 32'h0000_0001 << CTRL_RISE_IE_BIT;
	localparam logic [31:0] S_FALL = 32'h0000_0001 << STAT_FALL_BIT;
	localparam logic [31:0] S_RISE = 32'h0000_0001 << STAT_RISE_BIT;
	localparam logic [31:0] S_SEQ  = 32'h0000_0001 << STAT_SEQERR_BIT;
	localparam logic [31:0] S_SET  = 32'h0000_0001 << STAT_SETTLED_BIT;
	localparam logic [31:0] S_LVL  = 32'h0000_0001 << STAT_LEVEL_BIT;

	// ==========================================================
	// signals
	logic             core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0]      haddr, hwdata, hrdata;
	logic [1:0]       htrans, zone;
	logic [2:0]       hsize;
	logic [CMP_W-1:0] supply_cmp;
	logic             detect_signal_n, external_interrupt_zero;
	int               irq_count, n_errors, check_count;

	lvi_top #(.SETTLE_WAIT(SW)) lvi_top_i (
		.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_cmp(supply_cmp),
		.detect_signal_n(detect_signal_n), .external_interrupt_zero(external_interrupt_zero)
	);

	lvi_supply_model lvi_supply_model_i (
		.core_clk(core_clk), .zone(zone), .supply_cmp(supply_cmp),
		.external_interrupt_zero(external_interrupt_zero), .irq_count(irq_count)
	);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ==========================================================
	// reporting
	task automatic test_done();
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ==========================================================
	// bus access: hold each phase until hready is seen high at an edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			$display("[ERR] hready expected 1 seen %b", hreadyout);
			test_done();
		end
	endtask

	task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= is_wr;
		hsize  <= 3'b010;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0000_0000, r);
		chk(nm, e, r);
	endtask

	// bounded wait for the detect output to reach a level
	task automatic wait_det(input logic v);
		int n;
		n = 0;
		while (detect_signal_n !== v && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		chk("detect_signal_n", {31'h0, v}, {31'h0, detect_signal_n});
		if (detect_signal_n !== v) begin
			test_done();
		end
		repeat (2) @(posedge core_clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_errors = 0;
		check_count = 0;
		rst_n = 1'b0;
		zone = 2'h0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd_chk(OFS_CTRL, 32'h0000_0000, "control");
		zone <= 2'h2;
		repeat (8) @(posedge core_clk);
		chk("detect_signal_n", 32'h0000_0001, {31'h0, detect_signal_n});
		rd_chk(OFS_STATUS, S_LVL, "status");
		zone <= 2'h0;
		wr(OFS_CTRL, C_DET);
		repeat (SW + 4) @(posedge core_clk);
		rd_chk(OFS_STATUS, S_SET | S_LVL, "status");
		wr(OFS_CTRL, C_DET | C_FALL | C_RISE);
		// port output setup would follow here, after both enables
		rd_chk(OFS_CTRL, C_DET | C_FALL | C_RISE, "control");
		// fall with the fall enable set
		zone <= 2'h2;
		wait_det(1'b0);
		chk("irq count", 32'h0000_0001, irq_count);
		rd_chk(OFS_STATUS, S_SET | S_FALL, "status");
		// recovery with the rise enable set
		zone <= 2'h0;
		wait_det(1'b1);
		chk("irq count", 32'h0000_0002, irq_count);
		rd_chk(OFS_STATUS, S_SET | S_LVL | S_FALL | S_RISE, "status");
		wr(OFS_STATUS, 32'h0000_0000);
		rd_chk(OFS_STATUS, S_SET | S_LVL, "status");
		// fall with the fall enable clear: flag but no request
		wr(OFS_CTRL, C_DET | C_RISE);
		zone <= 2'h2;
		wait_det(1'b0);
		chk("irq count", 32'h0000_0002, irq_count);
		rd_chk(OFS_STATUS, S_SET | S_FALL, "status");
		// dip below the reset level blocks recovery
		zone <= 2'h3;
		repeat (6) @(posedge core_clk);
		zone <= 2'h0;
		repeat (10) @(posedge core_clk);
		chk("detect_signal_n", 32'h0000_0000, {31'h0, detect_signal_n});
		chk("irq count", 32'h0000_0002, irq_count);
		// orderly shutdown, then the forbidden single-write shutdown
		wr(OFS_CTRL, C_DET);
		wr(OFS_CTRL, 32'h0000_0000);
		// standby follows the write by one edge, the released level by one more
		repeat (2) @(posedge core_clk);
		chk("detect_signal_n", 32'h0000_0001, {31'h0, detect_signal_n});
		rd_chk(OFS_STATUS, S_LVL | S_FALL, "status");
		wr(OFS_CTRL, C_DET | C_FALL | C_RISE);
		repeat (SW + 4) @(posedge core_clk);
		wr(OFS_CTRL, 32'h0000_0000);
		rd_chk(OFS_STATUS, S_LVL | S_FALL | S_SEQ, "status");
		// unmapped offset reads zero and ignores writes
		wr(8'h40, 32'hFFFF_FFFF);
		rd_chk(8'h40, 32'h0000_0000, "unmapped");
		// second reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd_chk(OFS_STATUS, S_LVL, "status");
		rd_chk(OFS_CTRL, 32'h0000_0000, "control");
		// rise with the rise enable clear: level restored, no flag, no request
		wr(OFS_CTRL, C_DET);
		repeat (SW + 4) @(posedge core_clk);
		wr(OFS_CTRL, C_DET | C_FALL);
		zone <= 2'h2;
		wait_det(1'b0);
		chk("irq count", 32'h0000_0003, irq_count);
		zone <= 2'h0;
		wait_det(1'b1);
		chk("irq count", 32'h0000_0003, irq_count);
		// writing ones leaves the flags as they are
		wr(OFS_STATUS, S_FALL | S_RISE | S_SEQ);
		rd_chk(OFS_STATUS, S_SET | S_LVL | S_FALL, "status");
		test_done();
	end
endmodule
`default_nettype wire
